// ### verilog/t3cr_timer.sv
`timescale 1ns/1ps
module t3cr_timer
   import t3cr_pkg::*;
#(
   parameter int MACHINE_DIV = T3CR_MACHINE_DIV,
   parameter int BAUD_DIV    = T3CR_BAUD_DIV
) (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // Special-function-register bus
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   // External pins
   input  wire logic       count_input_pin,
   input  wire logic       ext_trigger_pin,
   // Serial port clock path
   input  wire logic       other_timer_overflow,
   output logic            rx_bit_tick,
   output logic            tx_bit_tick,
   // Interrupt request
   output logic            timer_irq
);

   // Control bits
   logic          overflow_flag;
   logic          external_event_flag;
   logic          rx_baud_select;
   logic          tx_baud_select;
   logic          ext_trigger_enable;
   logic          run_control;
   logic          counter_select;
   logic          capture_select;

   // Data bytes
   logic [7:0]    count_low;
   logic [7:0]    count_high;
   logic [7:0]    reload_low;
   logic [7:0]    reload_high;

   // Internal signals
   t3cr_mode_type mode;
   logic [T3CR_DIV_WIDTH-1:0] div_count;
   logic          machine_tick;
   logic          baud_tick;
   logic          count_edge;
   logic          trigger_edge;
   logic          increment;
   logic          rollover;
   logic          trigger_hit;
   logic          do_reload;
   logic          do_capture;
   logic          own_baud_tick;
   logic [15:0]   count_value;
   logic [15:0]   reload_value;
   logic [15:0]   next_count;
   logic          wr_control;
   logic          wr_count_low;
   logic          wr_count_high;
   logic          wr_reload_low;
   logic          wr_reload_high;

   // Mode decode from the run, baud and capture bits
   function automatic t3cr_mode_type decode_mode(input logic run, input logic rx_sel,
                                                 input logic tx_sel, input logic cap_sel);
      t3cr_mode_type result;
      result = T3CR_MODE_OFF;
      if (!run) begin
         result = T3CR_MODE_OFF;
      end else if (rx_sel || tx_sel) begin
         result = T3CR_MODE_BAUD;
      end else if (cap_sel) begin
         result = T3CR_MODE_CAPTURE;
      end else begin
         result = T3CR_MODE_RELOAD;
      end
      return result;
   endfunction

   // Address match for a write strobe
   function automatic logic write_hit(input logic wr, input logic [7:0] addr,
                                      input logic [7:0] target);
      return wr && (addr == target);
   endfunction

   // Pin synchronisers with falling-edge detection
   t3cr_edge_sync u_count_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin     (count_input_pin),
      .falling (count_edge)
   );

   t3cr_edge_sync u_trigger_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin     (ext_trigger_pin),
      .falling (trigger_edge)
   );

   // Serial port clock selection
   t3cr_clk_select u_clk_select (
      .ref_clk              (ref_clk),
      .rst                  (rst),
      .rx_baud_select       (rx_baud_select),
      .tx_baud_select       (tx_baud_select),
      .own_baud_tick        (own_baud_tick),
      .other_timer_overflow (other_timer_overflow),
      .rx_bit_tick          (rx_bit_tick),
      .tx_bit_tick          (tx_bit_tick)
   );

   // Mode and write strobes
   assign mode           = decode_mode(run_control, rx_baud_select, tx_baud_select, capture_select);
   assign wr_control     = write_hit(sfr_wr, sfr_addr, T3CR_ADDR_CONTROL);
   assign wr_count_low   = write_hit(sfr_wr, sfr_addr, T3CR_ADDR_COUNT_LOW);
   assign wr_count_high  = write_hit(sfr_wr, sfr_addr, T3CR_ADDR_COUNT_HIGH);
   assign wr_reload_low  = write_hit(sfr_wr, sfr_addr, T3CR_ADDR_RELOAD_LOW);
   assign wr_reload_high = write_hit(sfr_wr, sfr_addr, T3CR_ADDR_RELOAD_HIGH);

   // Core clock prescaler, wraps once per machine cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_count <= '0;
      end else if (div_count == T3CR_DIV_WIDTH'(MACHINE_DIV - 1)) begin
         div_count <= '0;
      end else begin
         div_count <= div_count + T3CR_DIV_WIDTH'(1);
      end
   end

   // Machine-cycle and two-clock enables
   assign machine_tick = (div_count == T3CR_DIV_WIDTH'(MACHINE_DIV - 1));
   assign baud_tick    = (div_count[0] == 1'b1) && (BAUD_DIV == T3CR_BAUD_DIV)
                         || (BAUD_DIV != T3CR_BAUD_DIV) && machine_tick;

   // Increment source and enable
   always_comb begin
      increment = 1'b0;
      if (run_control) begin
         if (counter_select) begin
            increment = count_edge;
         end else if (mode == T3CR_MODE_BAUD) begin
            increment = baud_tick;
         end else begin
            increment = machine_tick;
         end
      end
   end

   // Counter views and overflow
   assign count_value  = {count_high, count_low};
   assign reload_value = {reload_high, reload_low};
   assign rollover     = increment && (count_value == T3CR_COUNT_MAX);

   // Trigger edge acts only when enabled; it captures only outside baud mode
   assign trigger_hit = trigger_edge && ext_trigger_enable;
   assign do_capture  = trigger_hit && capture_select && !rx_baud_select && !tx_baud_select;

   // Reload on overflow in reload or baud mode, or on an enabled edge in reload mode or while stopped with capture and baud selects clear
   always_comb begin
      do_reload = 1'b0;
      case (mode)
         T3CR_MODE_RELOAD: begin
            do_reload = rollover || trigger_hit;
         end
         T3CR_MODE_BAUD: begin
            do_reload = rollover;
         end
         T3CR_MODE_CAPTURE: begin
            do_reload = 1'b0;
         end
         T3CR_MODE_OFF: begin
            do_reload = trigger_hit && !capture_select && !rx_baud_select && !tx_baud_select;
         end
         default: begin
            do_reload = 1'b0;
         end
      endcase
   end

   // Next counter value from reload, increment or hold
   always_comb begin
      next_count = count_value;
      if (do_reload) begin
         next_count = reload_value;
      end else if (increment) begin
         next_count = count_value + T3CR_COUNT_ONE;
      end
   end

   // Counter low byte, software write wins
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count_low <= T3CR_BYTE_RESET;
      end else if (wr_count_low) begin
         count_low <= sfr_wdata;
      end else begin
         count_low <= next_count[7:0];
      end
   end

   // Counter high byte, software write wins
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count_high <= T3CR_BYTE_RESET;
      end else if (wr_count_high) begin
         count_high <= sfr_wdata;
      end else begin
         count_high <= next_count[15:8];
      end
   end

   // Reload low byte, captured from the counter on an edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reload_low <= T3CR_BYTE_RESET;
      end else if (wr_reload_low) begin
         reload_low <= sfr_wdata;
      end else if (do_capture) begin
         reload_low <= count_low;
      end
   end

   // Reload high byte, captured from the counter on an edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reload_high <= T3CR_BYTE_RESET;
      end else if (wr_reload_high) begin
         reload_high <= sfr_wdata;
      end else if (do_capture) begin
         reload_high <= count_high;
      end
   end

   // Overflow flag, hardware set wins over a software clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         overflow_flag <= T3CR_CONTROL_RESET[T3CR_BIT_OVERFLOW];
      end else if (rollover && !rx_baud_select && !tx_baud_select) begin
         overflow_flag <= 1'b1;
      end else if (wr_control) begin
         overflow_flag <= sfr_wdata[T3CR_BIT_OVERFLOW];
      end
   end

   // External event flag, set by any enabled edge, also in baud mode
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         external_event_flag <= T3CR_CONTROL_RESET[T3CR_BIT_EXT_EVENT];
      end else if (trigger_hit) begin
         external_event_flag <= 1'b1;
      end else if (wr_control) begin
         external_event_flag <= sfr_wdata[T3CR_BIT_EXT_EVENT];
      end
   end

   // Software-owned control bits
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_baud_select     <= T3CR_CONTROL_RESET[T3CR_BIT_RX_BAUD];
         tx_baud_select     <= T3CR_CONTROL_RESET[T3CR_BIT_TX_BAUD];
         ext_trigger_enable <= T3CR_CONTROL_RESET[T3CR_BIT_EXT_ENABLE];
         run_control        <= T3CR_CONTROL_RESET[T3CR_BIT_RUN];
         counter_select     <= T3CR_CONTROL_RESET[T3CR_BIT_COUNTER_SEL];
         capture_select     <= T3CR_CONTROL_RESET[T3CR_BIT_CAPTURE_SEL];
      end else if (wr_control) begin
         rx_baud_select     <= sfr_wdata[T3CR_BIT_RX_BAUD];
         tx_baud_select     <= sfr_wdata[T3CR_BIT_TX_BAUD];
         ext_trigger_enable <= sfr_wdata[T3CR_BIT_EXT_ENABLE];
         run_control        <= sfr_wdata[T3CR_BIT_RUN];
         counter_select     <= sfr_wdata[T3CR_BIT_COUNTER_SEL];
         capture_select     <= sfr_wdata[T3CR_BIT_CAPTURE_SEL];
      end
   end

   // One-cycle overflow tick toward the serial port in baud mode
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         own_baud_tick <= 1'b0;
      end else begin
         own_baud_tick <= rollover && (mode == T3CR_MODE_BAUD);
      end
   end

   // Interrupt request from either flag
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         timer_irq <= 1'b0;
      end else begin
         timer_irq <= overflow_flag || external_event_flag;
      end
   end

   // Registered read data, zero when idle or unmapped
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sfr_rdata <= T3CR_READ_IDLE;
      end else if (sfr_rd) begin
         case (sfr_addr)
            T3CR_ADDR_CONTROL: begin
               sfr_rdata <= {overflow_flag, external_event_flag, rx_baud_select, tx_baud_select,
                             ext_trigger_enable, run_control, counter_select, capture_select};
            end
            T3CR_ADDR_RELOAD_LOW: begin
               sfr_rdata <= reload_low;
            end
            T3CR_ADDR_RELOAD_HIGH: begin
               sfr_rdata <= reload_high;
            end
            T3CR_ADDR_COUNT_LOW: begin
               sfr_rdata <= count_low;
            end
            T3CR_ADDR_COUNT_HIGH: begin
               sfr_rdata <= count_high;
            end
            default: begin
               sfr_rdata <= T3CR_READ_IDLE;
            end
         endcase
      end else begin
         sfr_rdata <= T3CR_READ_IDLE;
      end
   end

endmodule

// ### verilog/t3cr_pkg.sv
package t3cr_pkg;

   // Special-function-register addresses
   localparam logic [7:0] T3CR_ADDR_CONTROL     = 8'hc8;
   localparam logic [7:0] T3CR_ADDR_RELOAD_LOW  = 8'hca;
   localparam logic [7:0] T3CR_ADDR_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] T3CR_ADDR_COUNT_LOW   = 8'hcc;
   localparam logic [7:0] T3CR_ADDR_COUNT_HIGH  = 8'hcd;

   // Control register bit positions
   localparam int T3CR_BIT_OVERFLOW    = 7;
   localparam int T3CR_BIT_EXT_EVENT   = 6;
   localparam int T3CR_BIT_RX_BAUD     = 5;
   localparam int T3CR_BIT_TX_BAUD     = 4;
   localparam int T3CR_BIT_EXT_ENABLE  = 3;
   localparam int T3CR_BIT_RUN         = 2;
   localparam int T3CR_BIT_COUNTER_SEL = 1;
   localparam int T3CR_BIT_CAPTURE_SEL = 0;

   // Reset and constant values
   localparam logic [7:0]  T3CR_CONTROL_RESET = 8'h00;
   localparam logic [7:0]  T3CR_BYTE_RESET    = 8'h00;
   localparam logic [7:0]  T3CR_READ_IDLE     = 8'h00;
   localparam logic [15:0] T3CR_COUNT_MAX     = 16'hffff;
   localparam logic [15:0] T3CR_COUNT_ONE     = 16'h0001;
   localparam logic [15:0] T3CR_COUNT_ZERO    = 16'h0000;

   // Core clocks per timer increment and prescaler counter width
   localparam int T3CR_MACHINE_DIV = 12;
   localparam int T3CR_BAUD_DIV    = 2;
   localparam int T3CR_DIV_WIDTH   = 4;

   // Operating modes, one-hot
   typedef enum logic [3:0] {
      T3CR_MODE_OFF     = 4'b0001,
      T3CR_MODE_RELOAD  = 4'b0010,
      T3CR_MODE_CAPTURE = 4'b0100,
      T3CR_MODE_BAUD    = 4'b1000
   } t3cr_mode_type;

endpackage

// ### verilog/t3cr_edge_sync.sv
`timescale 1ns/1ps
module t3cr_edge_sync (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Asynchronous pin
   input  wire logic pin,
   // Falling-edge pulse
   output logic      falling
);

   logic stage_one;
   logic stage_two;
   logic previous;

   // Two-flop synchroniser, then one sample of history
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stage_one <= 1'b1;
         stage_two <= 1'b1;
         previous  <= 1'b1;
      end else begin
         stage_one <= pin;
         stage_two <= stage_one;
         previous  <= stage_two;
      end
   end

   // One-cycle pulse on a 1-to-0 change of successive samples
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         falling <= 1'b0;
      end else begin
         falling <= previous & ~stage_two;
      end
   end

endmodule

// ### verilog/t3cr_clk_select.sv
`timescale 1ns/1ps
module t3cr_clk_select (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Selects from the control register
   input  wire logic rx_baud_select,
   input  wire logic tx_baud_select,
   // Overflow sources
   input  wire logic own_baud_tick,
   input  wire logic other_timer_overflow,
   // Bit-clock ticks toward the serial port
   output logic      rx_bit_tick,
   output logic      tx_bit_tick
);

   // Route this timer or the other timer to each direction
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_bit_tick <= 1'b0;
         tx_bit_tick <= 1'b0;
      end else begin
         rx_bit_tick <= rx_baud_select ? own_baud_tick : other_timer_overflow;
         tx_bit_tick <= tx_baud_select ? own_baud_tick : other_timer_overflow;
      end
   end

endmodule

// ### test/t3cr_timer_checker.sv
`timescale 1ns/1ps
module t3cr_timer_checker
   import t3cr_pkg::*;
#(
   parameter int MACHINE_DIV = T3CR_MACHINE_DIV,
   parameter int BAUD_DIV    = T3CR_BAUD_DIV
) (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       rst,
   // Register bus
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // Pins, serial path and request
   input wire logic       count_input_pin,
   input wire logic       ext_trigger_pin,
   input wire logic       other_timer_overflow,
   input wire logic       rx_bit_tick,
   input wire logic       tx_bit_tick,
   input wire logic       timer_irq
);
   logic [5:0] ctl_sh;
   logic [3:0] cause_cnt;
   logic [3:0] wr_cnt;
   logic [3:0] quiet_cnt;
   logic       wr_ctl;
   logic       mapped;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Bus decode
   assign wr_ctl = sfr_wr && sfr_addr == T3CR_ADDR_CONTROL;
   assign mapped = sfr_addr == T3CR_ADDR_CONTROL || (sfr_addr >= 8'hca && sfr_addr <= 8'hcd);
   // Shadow of software-owned control bits
   always_ff @(posedge ref_clk) begin
      if (rst) ctl_sh <= 6'h00;
      else if (wr_ctl) ctl_sh <= sfr_wdata[5:0];
   end
   // Cycles since something that may raise a flag
   always_ff @(posedge ref_clk) begin
      if (rst || ctl_sh[2] || ctl_sh[3] || wr_ctl) cause_cnt <= 4'h0;
      else if (cause_cnt != 4'hf) cause_cnt <= cause_cnt + 4'h1;
   end
   // Cycles since the last control write
   always_ff @(posedge ref_clk) begin
      if (rst || wr_ctl) wr_cnt <= 4'h0;
      else if (wr_cnt != 4'hf) wr_cnt <= wr_cnt + 4'h1;
   end
   // Cycles in baud mode with the trigger disabled
   always_ff @(posedge ref_clk) begin
      if (rst || !(ctl_sh[5] || ctl_sh[4]) || ctl_sh[3] || wr_ctl) quiet_cnt <= 4'h0;
      else if (quiet_cnt != 4'hf) quiet_cnt <= quiet_cnt + 4'h1;
   end
   a_rx_route: assert property ((!ctl_sh[5] && !wr_ctl) |=> rx_bit_tick == $past(other_timer_overflow))
      else $error("receive tick does not follow other timer");
   a_tx_route: assert property ((!ctl_sh[4] && !wr_ctl) |=> tx_bit_tick == $past(other_timer_overflow))
      else $error("transmit tick does not follow other timer");
   a_tick_single: assert property (rx_bit_tick |=> !rx_bit_tick)
      else $error("receive tick longer than one cycle");
   a_read_idle: assert property (!sfr_rd |=> sfr_rdata == T3CR_READ_IDLE)
      else $error("read data without a read");
   a_read_unmap: assert property ((sfr_rd && !mapped) |=> sfr_rdata == T3CR_READ_IDLE)
      else $error("unmapped read not zero");
   a_read_ctl: assert property ((sfr_rd && sfr_addr == T3CR_ADDR_CONTROL && !sfr_wr) |=>
      sfr_rdata[5:0] == $past(ctl_sh))
      else $error("control bits read back wrong");
   a_irq_cause: assert property ($rose(timer_irq) |-> cause_cnt < 4'h6)
      else $error("request raised without cause");
   a_irq_clear: assert property ($fell(timer_irq) |-> wr_cnt < 4'h4)
      else $error("request dropped without a write");
   a_baud_quiet: assert property ($rose(timer_irq) |-> quiet_cnt < 4'h4)
      else $error("overflow request in baud mode");
   cover property (rx_bit_tick && ctl_sh[5]);
   cover property ($rose(timer_irq));
   cover property (sfr_rd && !mapped);
endmodule
bind t3cr_timer t3cr_timer_checker #(.MACHINE_DIV(MACHINE_DIV), .BAUD_DIV(BAUD_DIV)) u_chk (
   .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .count_input_pin(count_input_pin),
   .ext_trigger_pin(ext_trigger_pin), .other_timer_overflow(other_timer_overflow),
   .rx_bit_tick(rx_bit_tick), .tx_bit_tick(tx_bit_tick), .timer_irq(timer_irq));

// ### test/t3cr_far_side.sv
`timescale 1ns/1ps
module t3cr_far_side (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Requests from the bench
   input wire logic trig_req,
   input wire logic cnt_req,
   input wire logic ovf_req,
   // Ticks from the timer
   input wire logic rx_bit_tick,
   input wire logic tx_bit_tick,
   // Pins and other timer
   output logic     ext_trigger_pin,
   output logic     count_input_pin,
   output logic     other_timer_overflow,
   output int       rx_cnt,
   output int       tx_cnt
);
   int trig_low;
   int cnt_low;
   // Pins idle high on their pull-ups, pulled low for six cycles
   always_ff @(posedge ref_clk) begin
      if (rst) trig_low <= 0;
      else trig_low <= trig_req ? 6 : (trig_low > 0 ? trig_low - 1 : 0);
      if (rst) cnt_low <= 0;
      else cnt_low <= cnt_req ? 6 : (cnt_low > 0 ? cnt_low - 1 : 0);
   end
   assign ext_trigger_pin = trig_low == 0;
   assign count_input_pin = cnt_low == 0;
   // One-cycle overflow of the other timer
   always_ff @(posedge ref_clk) begin
      other_timer_overflow <= !rst && ovf_req;
   end
   // Serial port bit clocks seen
   always_ff @(posedge ref_clk) begin
      if (rst) rx_cnt <= 0;
      else if (rx_bit_tick) rx_cnt <= rx_cnt + 1;
      if (rst) tx_cnt <= 0;
      else if (tx_bit_tick) tx_cnt <= tx_cnt + 1;
   end
endmodule

// ### test/timer2_capture_reload_baud_bench.sv
`timescale 1ns/1ps
module timer2_capture_reload_baud_bench;
   import t3cr_pkg::*;
   logic       ref_clk, rst, sfr_wr, sfr_rd, trig_req, cnt_req, ovf_req;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic       ext_trigger_pin, count_input_pin, other_timer_overflow, rx_bit_tick, tx_bit_tick, timer_irq;
   int         rx_cnt, tx_cnt, error_cnt, samples_checked, k, n, m, per;
   logic [7:0] mreg [0:4];
   t3cr_timer DUT (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .count_input_pin(count_input_pin),
      .ext_trigger_pin(ext_trigger_pin), .other_timer_overflow(other_timer_overflow),
      .rx_bit_tick(rx_bit_tick), .tx_bit_tick(tx_bit_tick), .timer_irq(timer_irq));
   t3cr_far_side u_far (.ref_clk(ref_clk), .rst(rst), .trig_req(trig_req), .cnt_req(cnt_req),
      .ovf_req(ovf_req), .rx_bit_tick(rx_bit_tick), .tx_bit_tick(tx_bit_tick),
      .ext_trigger_pin(ext_trigger_pin), .count_input_pin(count_input_pin),
      .other_timer_overflow(other_timer_overflow), .rx_cnt(rx_cnt), .tx_cnt(tx_cnt));
   // 20 MHz core clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   function automatic int idx(input logic [7:0] a);
      return (a == T3CR_ADDR_CONTROL) ? 0 : int'(a - 8'hc9);
   endfunction
   function automatic logic sig(input int sel);
      return sel == 0 ? timer_irq : (sel == 1 ? rx_bit_tick : tx_bit_tick);
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         error_cnt++;
      end
   endtask
   task automatic complete_run;
      $display("mismatches %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge ref_clk);
      #2;
   endtask
   // Register write, mirrored in the model
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      tick(1);
      sfr_wr = 1'b0;
      if (a == T3CR_ADDR_CONTROL || (a >= 8'hca && a <= 8'hcd)) mreg[idx(a)] = d;
      // Idle cycle so a following call never re-raises the strobe in the same step
      tick(1);
   endtask
   // Register read compared with the model
   task automatic rd(input logic [7:0] a);
      sfr_addr = a;
      sfr_rd = 1'b1;
      tick(1);
      sfr_rd = 1'b0;
      check(sfr_rdata, (a == T3CR_ADDR_CONTROL || (a >= 8'hca && a <= 8'hcd)) ? mreg[idx(a)] : T3CR_READ_IDLE);
      // Idle cycle between back-to-back reads
      tick(1);
   endtask
   task automatic pulse(input int sel);
      trig_req = sel == 0;
      cnt_req = sel == 1;
      ovf_req = sel == 2;
      tick(1);
      {trig_req, cnt_req, ovf_req} = 3'b000;
      tick(12);
   endtask
   // Bounded wait for a level, then period to the next one
   task automatic wait_hi(input int sel, input int bound);
      int i;
      for (i = 0; i < bound && sig(sel) !== 1'b1; i++) tick(1);
      if (i == bound) begin
         $display("unexpected at %0t: timeout %h %h", $time, sel, 1);
         error_cnt++;
         complete_run;
      end
   endtask
   task automatic measure(input int sel);
      wait_hi(sel, 200);
      tick(1);
      for (per = 1; per < 200 && sig(sel) !== 1'b1; per++) tick(1);
   endtask
   initial begin
      {sfr_wr, sfr_rd, trig_req, cnt_req, ovf_req} = 5'b00000;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      rst = 1'b1;
      error_cnt = 0;
      samples_checked = 0;
      mreg = '{default: 8'h00};
      k = $urandom(80172);
      tick(6);
      rst = 1'b0;
      // Reset values, unmapped read, random read-back, stopped counter
      for (k = 0; k < 6; k++) rd(8'(8'hc8 + k));
      for (k = 1; k < 6; k++) wr(8'(8'hc8 + k), 8'($urandom));
      tick(100);
      for (k = 0; k < 6; k++) rd(8'(8'hc8 + k));
      // Overflow in reload mode, then in capture mode without trigger
      for (k = 0; k < 2; k++) begin
         wr(T3CR_ADDR_RELOAD_LOW, 8'($urandom_range(0, 127)));
         wr(T3CR_ADDR_COUNT_HIGH, 8'hff);
         wr(T3CR_ADDR_COUNT_LOW, 8'hfe);
         wr(T3CR_ADDR_CONTROL, 8'(8'h04 + k));
         wait_hi(0, 100);
         mreg[0] = 8'(8'h84 + k);
         rd(T3CR_ADDR_CONTROL);
         wr(T3CR_ADDR_CONTROL, 8'h00);
         mreg[4] = k ? 8'h00 : mreg[2];
         rd(T3CR_ADDR_COUNT_HIGH);
         rd(T3CR_ADDR_RELOAD_LOW);
         check({7'h00, timer_irq}, 8'h00);
      end
      // Trigger edge with every mix of enable and capture select, stopped and running on the idle pin
      for (k = 0; k < 8; k++) begin
         for (n = 1; n < 5; n++) wr(8'(8'hc9 + n), 8'($urandom));
         wr(T3CR_ADDR_CONTROL, 8'((k[1] ? 8'h08 : 8'h00) | (k[2] ? 8'h06 : 8'h00) | k[0]));
         pulse(0);
         if (k[1]) begin
            if (k[0]) begin
               mreg[1] = mreg[3];
               mreg[2] = mreg[4];
            end else begin
               mreg[3] = mreg[1];
               mreg[4] = mreg[2];
            end
            mreg[0] = mreg[0] | 8'h40;
         end
         check({7'h00, timer_irq}, {7'h00, k[1]});
         for (n = 0; n < 6; n++) rd(8'(8'hc8 + n));
         wr(T3CR_ADDR_CONTROL, 8'h00);
      end
      // Counting falling edges of the count pin
      wr(T3CR_ADDR_COUNT_HIGH, 8'h00);
      wr(T3CR_ADDR_COUNT_LOW, 8'h00);
      wr(T3CR_ADDR_CONTROL, 8'h06);
      n = $urandom_range(1, 6);
      repeat (n) pulse(1);
      wr(T3CR_ADDR_CONTROL, 8'h00);
      mreg[3] = 8'(n);
      rd(T3CR_ADDR_COUNT_LOW);
      // Other timer overflow reaches both paths
      n = rx_cnt;
      m = tx_cnt;
      repeat (3) pulse(2);
      check(8'(rx_cnt - n), 8'h03);
      check(8'(tx_cnt - m), 8'h03);
      // Baud generator period, no overflow flag
      for (k = 0; k < 2; k++) begin
         n = $urandom_range(2, 9);
         wr(T3CR_ADDR_RELOAD_HIGH, 8'hff);
         wr(T3CR_ADDR_RELOAD_LOW, 8'(256 - n));
         wr(T3CR_ADDR_COUNT_HIGH, 8'hff);
         wr(T3CR_ADDR_COUNT_LOW, 8'hff);
         m = k ? rx_cnt : tx_cnt;
         wr(T3CR_ADDR_CONTROL, k ? 8'h14 : 8'h24);
         measure(k + 1);
         check(8'(per), 8'(2 * n));
         check(8'((k ? rx_cnt : tx_cnt) - m), 8'h00);
         rd(T3CR_ADDR_CONTROL);
         wr(T3CR_ADDR_CONTROL, 8'h00);
      end
      // Trigger edge in baud mode sets the event flag only, capture select ignored
      wr(T3CR_ADDR_CONTROL, 8'h2d);
      pulse(0);
      mreg[0] = 8'h6d;
      for (n = 0; n < 4; n++) rd(8'(8'hc8 + n));
      check({7'h00, timer_irq}, 8'h01);
      wr(T3CR_ADDR_CONTROL, 8'h00);
      tick(2);
      check({7'h00, timer_irq}, 8'h00);
      complete_run;
   end
endmodule
